//--- logic/store_exec.sv
// Execution unit for multi-register stores and immediate word stores.
// Assumes a combinational register read port, a word memory write port
// held until memReady, and an APB master for its control registers.
// Contract
// - Ascending end equals base plus four per register
// - Ascending limit check gates all stores
// - Ascending register order, word writes, step four
// - Short ascending non-lowest base stores unknown
// - Ascending writeback through checked stack update
// - Descending starts base minus four per register
// - Descending stack stores each checked against limit
// - Descending writeback is base minus four per register
// - Wide descending mask built from link bit
// - Wide descending base fifteen or few registers unpredictable
// - Wide descending undefined without main extension
// - Writeback base in mask: chosen outcome
// - Single register wide store: chosen outcome
// - Empty mask: undefined or no-operation
// - Short push fixes stack base, writeback
// - Short word store scaled five-bit offset
// - Stack-relative word store scaled byte offset
// - Wide lists hold registers zero to twelve plus link
// - Update flag selects base writeback
// - Wide word store base fifteen undefined
`timescale 1ns/100ps
`default_nettype none
module store_exec
  import store_exec_pkg::*;
#(
  parameter logic [31:0] UNKNOWN_WORD = 32'h0000_0000  // Value for unknown base
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        issueValid,
  output logic             issueReady,
  input  wire logic [31:0] instr,
  input  wire logic        instrIs32,
  input  wire logic        condPass,
  output logic      [3:0]  regRdAddr,
  input  wire logic [31:0] regRdData,
  output logic             memValid,
  output logic      [31:0] memAddr,
  output logic      [31:0] memData,
  input  wire logic        memReady,
  output logic             wbValid,
  output logic      [3:0]  wbReg,
  output logic      [31:0] wbData,
  output logic             limitFault,
  output logic             undefInstr,
  output logic             instrDone
);
  import store_exec_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  // Count of set bits in a mask
  function automatic logic [4:0] popCount(input logic [15:0] m);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < 16; i++) begin
      c = c + {4'h0, m[i]};
    end
    return c;
  endfunction

  // Index of lowest set bit, zero when empty
  function automatic logic [3:0] lowestBit(input logic [15:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // ****************************************
  // APB registers
  // ****************************************
  logic [2:0]  ctrl_q,  ctrl_d;     // Main ext, nop policy, limit enable
  logic [31:0] splim_q, splim_d;    // Stack limit value
  logic        fltSt_q, fltSt_d;    // Sticky limit fault
  logic        undSt_q, undSt_d;    // Sticky undefined
  logic [31:0] rdat_q,  rdat_d;     // Read data
  logic        busy;                // Sequencer active
  logic        hit;                 // Address mapped
  logic        wrAcc;               // Write access phase

  // Answer in the access cycle, no wait states
  assign pready  = psel && penable;
  assign pslverr = pready && !hit;
  assign prdata  = rdat_q;

  // Address decode, write effects and read capture
  always_comb begin
    hit     = 1'b0;
    ctrl_d  = ctrl_q;
    splim_d = splim_q;
    fltSt_d = fltSt_q;
    undSt_d = undSt_q;
    rdat_d  = rdat_q;
    wrAcc   = psel && penable && pwrite;
    if (paddr == `OFF_CTRL) begin
      hit = 1'b1;
      if (wrAcc) begin
        ctrl_d = pwdata[2:0];
      end
    end else if (paddr == `OFF_STAT) begin
      hit = 1'b1;
      // Write one to clear
      if (wrAcc && pwdata[`STAT_FAULT]) begin
        fltSt_d = 1'b0;
      end
      if (wrAcc && pwdata[`STAT_UNDEF]) begin
        undSt_d = 1'b0;
      end
    end else if (paddr == `OFF_SPLIM) begin
      hit = 1'b1;
      if (wrAcc) begin
        splim_d = pwdata;
      end
    end
    // Hardware set wins over clear
    if (limitFault) begin
      fltSt_d = 1'b1;
    end
    if (undefInstr) begin
      undSt_d = 1'b1;
    end
    // Capture read data in the setup cycle
    if (psel && !penable) begin
      if (paddr == `OFF_CTRL) begin
        rdat_d = {29'h0, ctrl_q};
      end else if (paddr == `OFF_STAT) begin
        rdat_d = {29'h0, undSt_q, fltSt_q, busy};
      end else if (paddr == `OFF_SPLIM) begin
        rdat_d = splim_q;
      end else begin
        rdat_d = 32'h0000_0000;
      end
    end
  end

  // Register file flops
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q  <= `CTRL_RST;
      splim_q <= 32'h0000_0000;
      fltSt_q <= 1'b0;
      undSt_q <= 1'b0;
      rdat_q  <= 32'h0000_0000;
    end else begin
      ctrl_q  <= ctrl_d;
      splim_q <= splim_d;
      fltSt_q <= fltSt_d;
      undSt_q <= undSt_d;
      rdat_q  <= rdat_d;
    end
  end

  // ****************************************
  // Decode
  // ****************************************
  logic [15:0] hw1, hw2;            // Halfwords of the instruction
  logic        recog;               // Known store encoding
  logic        needMain;            // Needs main extension
  logic        unpred;              // Unpredictable case
  logic        dUndef;              // Answer as undefined
  logic        dNop;                // Answer as no-operation
  kind_t       dKind;               // Store family
  logic [3:0]  dBase;               // Base register
  logic [15:0] dMask;               // Register set
  logic        dWback;              // Writeback requested
  logic        dIs32;               // Wide multi-store
  logic [31:0] dImm;                // Word store offset
  logic [4:0]  dCnt;                // Registers selected

  assign hw1 = instr[31:16];
  assign hw2 = instr[15:0];

  // Field decode of all supported encodings
  always_comb begin
    recog    = 1'b1;
    needMain = 1'b0;
    unpred   = 1'b0;
    dKind    = KIND_ASC;
    dBase    = 4'h0;
    dMask    = 16'h0000;
    dWback   = 1'b0;
    dIs32    = 1'b0;
    dImm     = 32'h0000_0000;
    if (!instrIs32 && hw2[15:11] == `OP_STM16) begin
      dBase  = {1'b0, hw2[10:8]};
      dMask  = {8'h00, hw2[7:0]};
      dWback = 1'b1;
    end else if (!instrIs32 && hw2[15:9] == `OP_PUSH16) begin
      dKind  = KIND_DESC;
      dBase  = `SP_NUM;
      dMask  = {1'b0, hw2[8], 6'h00, hw2[7:0]};
      dWback = 1'b1;
    end else if (!instrIs32 && hw2[15:11] == `OP_STR1) begin
      dKind  = KIND_WORD;
      dBase  = {1'b0, hw2[5:3]};
      dMask  = 16'h0001 << hw2[2:0];
      dImm   = {25'h0, hw2[10:6], 2'b00};
    end else if (!instrIs32 && hw2[15:11] == `OP_STR2) begin
      dKind  = KIND_WORD;
      dBase  = `SP_NUM;
      dMask  = 16'h0001 << hw2[10:8];
      dImm   = {22'h0, hw2[7:0], 2'b00};
    end else if (instrIs32 && {hw1[15:6], hw1[4]} == `OP_STM32) begin
      needMain = 1'b1;
      dIs32  = 1'b1;
      dBase  = hw1[3:0];
      dMask  = {1'b0, hw2[14], 1'b0, hw2[12:0]};
      dWback = hw1[5];
    end else if (instrIs32 && {hw1[15:6], hw1[4]} == `OP_STMDB32) begin
      needMain = 1'b1;
      dIs32  = 1'b1;
      dKind  = KIND_DESC;
      dBase  = hw1[3:0];
      dMask  = {1'b0, hw2[14], 1'b0, hw2[12:0]};
      dWback = hw1[5];
    end else if (instrIs32 && hw1[15:4] == `OP_STR3) begin
      needMain = 1'b1;
      dKind  = KIND_WORD;
      dBase  = hw1[3:0];
      dMask  = 16'h0001 << hw2[15:12];
      dImm   = {20'h0, hw2[11:0]};
      recog  = hw1[3:0] != `PC_NUM;
      unpred = hw2[15:12] == `PC_NUM;
    end else begin
      recog  = 1'b0;
    end
    dCnt = popCount(dMask);
    // Empty set, or wide base of fifteen; one register runs as written
    if (dKind != KIND_WORD && dCnt == 5'h00) begin
      unpred = 1'b1;
    end
    if (dIs32 && dBase == `PC_NUM) begin
      unpred = 1'b1;
    end
    // Policy bit picks no-operation over undefined
    dNop   = recog && unpred && ctrl_q[`CTRL_NOP] && !(needMain && !ctrl_q[`CTRL_MAIN]);
    dUndef = !recog || (needMain && !ctrl_q[`CTRL_MAIN]) || (unpred && !dNop);
  end

  // ****************************************
  // Sequencer
  // ****************************************
  state_t      st_q,    st_d;       // State
  kind_t       kind_q,  kind_d;     // Family
  logic [15:0] mask_q,  mask_d;     // Registers still to store
  logic [3:0]  base_q,  base_d;     // Base register
  logic        wb_q,    wb_d;       // Writeback pending
  logic        unk_q,   unk_d;      // Base stores unknown
  logic        lim_q,   lim_d;      // Limit applies
  logic [31:0] addr_q,  addr_d;     // Current address
  logic [31:0] wbv_q,   wbv_d;      // Writeback value
  logic        mv_q,    mv_d;       // Memory write valid
  logic [31:0] ma_q,    ma_d;       // Memory address
  logic [31:0] md_q,    md_d;       // Memory data
  logic        wv_q,    wv_d;       // Writeback pulse
  logic        flt_q,   flt_d;      // Fault pulse
  logic        und_q,   und_d;      // Undefined pulse
  logic        dn_q,    dn_d;       // Done pulse
  logic [31:0] four;                // Bytes of all selected words
  logic [3:0]  cur;                 // Register being stored
  logic        limEn;               // Limit enabled

  assign issueReady = st_q == ST_IDLE;
  assign busy       = st_q != ST_IDLE;
  assign cur        = lowestBit(mask_q);
  assign regRdAddr  = (st_q == ST_IDLE) ? dBase : cur;
  assign limEn      = ctrl_q[`CTRL_LIMEN];
  assign four       = {25'h0, dCnt, 2'b00};
  assign memValid   = mv_q;
  assign memAddr    = ma_q;
  assign memData    = md_q;
  assign wbValid    = wv_q;
  assign wbReg      = base_q;
  assign wbData     = wbv_q;
  assign limitFault = flt_q;
  assign undefInstr = und_q;
  assign instrDone  = dn_q;

  // Next state of the store sequencer
  always_comb begin
    st_d   = st_q;
    kind_d = kind_q;
    mask_d = mask_q;
    base_d = base_q;
    wb_d   = wb_q;
    unk_d  = unk_q;
    lim_d  = lim_q;
    addr_d = addr_q;
    wbv_d  = wbv_q;
    mv_d   = mv_q;
    ma_d   = ma_q;
    md_d   = md_q;
    wv_d   = 1'b0;
    flt_d  = 1'b0;
    und_d  = 1'b0;
    dn_d   = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (issueValid) begin
          kind_d = dKind;
          base_d = dBase;
          wb_d   = dWback;
          mask_d = dMask;
          if (!condPass) begin
            dn_d = 1'b1;
          end else if (dUndef) begin
            und_d = 1'b1;
            dn_d  = 1'b1;
          end else if (dNop) begin
            dn_d = 1'b1;
          end else begin
            st_d = ST_LOAD;
            // Base in set with writeback stores unknown, unless lowest in a short list
            unk_d = dWback && dMask[dBase]
                    && (dIs32 || dBase != lowestBit(dMask));
            lim_d = 1'b0;
            if (dKind == KIND_ASC) begin
              addr_d = regRdData;
              wbv_d  = regRdData + four;
              lim_d  = dBase == `SP_NUM && dWback && !dMask[`SP_NUM] && limEn;
              if (lim_d && wbv_d < splim_q) begin
                mask_d = 16'h0000;
              end
            end else if (dKind == KIND_DESC) begin
              addr_d = regRdData - four;
              wbv_d  = regRdData - four;
              lim_d  = dBase == `SP_NUM && dWback && limEn;
            end else begin
              addr_d = regRdData + dImm;
              wbv_d  = regRdData;
            end
          end
        end
      end
      ST_LOAD: begin
        if (mask_q == 16'h0000) begin
          if (wb_q) begin
            st_d = ST_WB;
          end else begin
            st_d = ST_IDLE;
            dn_d = 1'b1;
          end
        end else if (kind_q == KIND_DESC && lim_q && addr_q < splim_q) begin
          mask_d = mask_q & ~(16'h0001 << cur);
        end else begin
          st_d = ST_PUSH;
          mv_d = 1'b1;
          ma_d = addr_q;
          md_d = (unk_q && cur == base_q) ? UNKNOWN_WORD : regRdData;
        end
      end
      ST_PUSH: begin
        // Hold the write until taken
        if (memReady) begin
          mv_d   = 1'b0;
          st_d   = ST_LOAD;
          mask_d = mask_q & ~(16'h0001 << cur);
          addr_d = addr_q + `WORD_BYTES;
        end
      end
      ST_WB: begin
        // Stack update checked against the limit
        if (base_q == `SP_NUM && limEn && wbv_q < splim_q) begin
          flt_d = 1'b1;
        end else begin
          wv_d = 1'b1;
        end
        dn_d = 1'b1;
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer flops
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q   <= ST_IDLE;
      kind_q <= KIND_ASC;
      mask_q <= 16'h0000;
      base_q <= 4'h0;
      wb_q   <= 1'b0;
      unk_q  <= 1'b0;
      lim_q  <= 1'b0;
      addr_q <= 32'h0000_0000;
      wbv_q  <= 32'h0000_0000;
      mv_q   <= 1'b0;
      ma_q   <= 32'h0000_0000;
      md_q   <= 32'h0000_0000;
      wv_q   <= 1'b0;
      flt_q  <= 1'b0;
      und_q  <= 1'b0;
      dn_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      kind_q <= kind_d;
      mask_q <= mask_d;
      base_q <= base_d;
      wb_q   <= wb_d;
      unk_q  <= unk_d;
      lim_q  <= lim_d;
      addr_q <= addr_d;
      wbv_q  <= wbv_d;
      mv_q   <= mv_d;
      ma_q   <= ma_d;
      md_q   <= md_d;
      wv_q   <= wv_d;
      flt_q  <= flt_d;
      und_q  <= und_d;
      dn_q   <= dn_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic [31:0] lastA_q;             // Address of last taken write
  logic        seen_q;              // A write was taken this instruction

  // Tracks taken writes for ordering checks
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lastA_q <= 32'h0000_0000;
      seen_q  <= 1'b0;
    end else if (issueValid && issueReady) begin
      seen_q  <= 1'b0;
    end else if (mv_q && memReady) begin
      lastA_q <= ma_q;
      seen_q  <= 1'b1;
    end
  end

  sequence s_accept;
    issueValid && issueReady;
  endsequence

  property p_condFail;
    @(posedge ref_clk) disable iff (!nrst)
    s_accept and !condPass |=> dn_q && !mv_q && !wv_q && !und_q;
  endproperty
  a_condFail: assert property (p_condFail) else $error("failed condition had effect");

  property p_hold;
    @(posedge ref_clk) disable iff (!nrst)
    mv_q && !memReady |=> mv_q && $stable(ma_q) && $stable(md_q);
  endproperty
  a_hold: assert property (p_hold) else $error("write dropped before taken");

  property p_step;
    @(posedge ref_clk) disable iff (!nrst)
    $rose(mv_q) && seen_q && kind_q != KIND_DESC |-> ma_q == lastA_q + `WORD_BYTES;
  endproperty
  a_step: assert property (p_step) else $error("address did not step by four");

  property p_ascLim;
    @(posedge ref_clk) disable iff (!nrst)
    mv_q && kind_q == KIND_ASC && lim_q |-> wbv_q >= splim_q;
  endproperty
  a_ascLim: assert property (p_ascLim) else $error("store past stack limit");

  property p_descLim;
    @(posedge ref_clk) disable iff (!nrst)
    mv_q && kind_q == KIND_DESC && lim_q |-> ma_q >= splim_q;
  endproperty
  a_descLim: assert property (p_descLim) else $error("word below stack limit");

  property p_wbCheck;
    @(posedge ref_clk) disable iff (!nrst)
    wv_q && wbReg == `SP_NUM && limEn |-> wbData >= splim_q && !flt_q;
  endproperty
  a_wbCheck: assert property (p_wbCheck) else $error("unchecked stack update");

  property p_wbFlag;
    @(posedge ref_clk) disable iff (!nrst)
    wv_q || flt_q |-> wb_q && dn_q;
  endproperty
  a_wbFlag: assert property (p_wbFlag) else $error("writeback without flag");

  property p_noMain;
    @(posedge ref_clk) disable iff (!nrst)
    s_accept and condPass && needMain && !ctrl_q[`CTRL_MAIN] |=> und_q ##1 !mv_q;
  endproperty
  a_noMain: assert property (p_noMain) else $error("wide store ran without main ext");

  property p_empty;
    @(posedge ref_clk) disable iff (!nrst)
    s_accept and condPass && dKind != KIND_WORD && dMask == 16'h0000 |=> dn_q && !mv_q;
  endproperty
  a_empty: assert property (p_empty) else $error("empty set did not end at once");

endmodule // store_exec
`default_nettype wire

//--- logic/store_exec_defs.svh
// Constants for the multi-register and word store execution unit.
// Assumes inclusion by the package and the testbench only.
`ifndef STORE_EXEC_DEFS_SVH
`define STORE_EXEC_DEFS_SVH
// Register byte offsets
`define OFF_CTRL    12'h000
`define OFF_STAT    12'h004
`define OFF_SPLIM   12'h008
// Control bits and reset value
`define CTRL_MAIN   0
`define CTRL_NOP    1
`define CTRL_LIMEN  2
`define CTRL_RST    3'h1
// Status bits
`define STAT_BUSY   0
`define STAT_FAULT  1
`define STAT_UNDEF  2
// Register numbers and word size
`define SP_NUM      4'hd
`define PC_NUM      4'hf
`define WORD_BYTES  32'h0000_0004
// Opcode patterns
`define OP_STM16    5'h18
`define OP_PUSH16   7'h5a
`define OP_STR1     5'h0c
`define OP_STR2     5'h12
`define OP_STM32    11'h744
`define OP_STMDB32  11'h748
`define OP_STR3     12'hf8c
`endif

//--- logic/store_exec_pkg.sv
// Types shared by the store execution unit.
// Assumes store_exec_defs.svh is on the include path.
package store_exec_pkg;
  `include "store_exec_defs.svh"
  // Store family of the accepted instruction
  typedef enum logic [1:0] {KIND_ASC, KIND_DESC, KIND_WORD} kind_t;
  // Execution sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_PUSH, ST_WB} state_t;
endpackage

//--- sim/mem_model.sv
// Word-write memory partner for the store execution unit.
// Assumes the unit holds memValid, memAddr and memData until memReady.
`timescale 1ns/100ps
`default_nettype none
module mem_model (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        memValid,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] memData,
  input  wire logic [3:0]  stall,     // Wait cycles before a word is taken
  input  wire logic        clr,       // Empties the write log
  output logic             memReady
);
  logic [3:0]  waitQ;                 // Cycles the current word has waited
  logic [31:0] wrCount;               // Words logged since last clear
  logic [31:0] wrAddr [16];           // Logged addresses
  logic [31:0] wrData [16];           // Logged data
  // Zero stall answers in the request cycle, else after the wait
  assign memReady = memValid && (waitQ >= stall);
  // Wait counter and write log
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      waitQ   <= 4'h0;
      wrCount <= 32'h0;
    end else if (clr) begin
      wrCount <= 32'h0;
    end else if (memValid && memReady) begin
      waitQ <= 4'h0;
      wrAddr[wrCount[3:0]] <= memAddr;
      wrData[wrCount[3:0]] <= memData;
      wrCount <= wrCount + 32'h1;
    end else if (memValid) begin
      waitQ <= waitQ + 4'h1;
    end
  end
endmodule // mem_model
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the store execution unit.
// Assumes store_exec_pkg, store_exec and mem_model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "store_exec_defs.svh"
module testbench;
  localparam logic [31:0] UNK = 32'h5a5a_a5a5;  // Stand-in for the unknown base word
  logic        ref_clk = 1'b0, nrst = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, instr = 32'h0, regRdData, memAddr, memData, wbData;
  logic        issueValid = 1'b0, issueReady, instrIs32 = 1'b0, condPass = 1'b0;
  logic        memValid, memReady, wbValid, limitFault, undefInstr, instrDone;
  logic [3:0]  regRdAddr, wbReg, wbRegHit, stall = 4'h0;
  logic [31:0] rf [16];                       // Register file seen by the unit
  logic [31:0] wbDataHit;                     // Captured writeback value
  logic        wbHit, faultHit, undefHit, doneHit;
  int          err_count = 0, checks = 0, cycles = 0, doneCycles;
  assign regRdData = rf[regRdAddr];
  store_exec #(.UNKNOWN_WORD(UNK)) dut (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .issueValid, .issueReady, .instr, .instrIs32,
    .condPass, .regRdAddr, .regRdData, .memValid, .memAddr, .memData, .memReady, .wbValid,
    .wbReg, .wbData, .limitFault, .undefInstr, .instrDone);
  mem_model mem (.ref_clk, .nrst, .memValid, .memAddr, .memData, .stall,
    .clr(issueValid & issueReady), .memReady);
  always #20 ref_clk = ~ref_clk;
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        e;
    apb(1'b1, a, d, x, e);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eErr);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h0, d, e);
    check(d, exp);
    check({31'h0, e}, {31'h0, eErr});
  endtask
  function automatic logic [31:0] enc32(input logic [9:0] op, input logic w,
      input logic [3:0] rn, input logic m, input logic [12:0] l);
    return {op, w, 1'b0, rn, 1'b0, m, 1'b0, l};
  endfunction
  // Issue one instruction and record its outcome until done
  task automatic run(input logic [31:0] ins, input logic w32, input logic cp);
    logic rdyLow;                             // Issue refused while busy
    @(posedge ref_clk);
    instr      <= ins;
    instrIs32  <= w32;
    condPass   <= cp;
    issueValid <= 1'b1;
    {wbHit, faultHit, undefHit, doneHit} = 4'h0;
    rdyLow = 1'b0;
    @(posedge ref_clk);
    issueValid <= 1'b0;
    for (doneCycles = 0; doneCycles < 300 && !doneHit; doneCycles++) begin
      @(negedge ref_clk);
      if (wbValid === 1'b1) begin
        wbHit = 1'b1;
        wbRegHit = wbReg;
        wbDataHit = wbData;
      end
      faultHit |= (limitFault === 1'b1);
      undefHit |= (undefInstr === 1'b1);
      rdyLow |= (issueReady === 1'b0);
      doneHit = (instrDone === 1'b1);
    end
    check({31'h0, doneHit}, 32'h1);
    check({30'h0, rdyLow, issueReady}, {30'h0, doneCycles > 1, 1'b1});
  endtask
  // Compare logged words, flags {wb,fault,undef} and writeback
  task automatic judge(input logic [31:0] a0, input logic [15:0] mask, input int uk,
                       input logic [2:0] flg, input logic [3:0] wr_, input logic [31:0] wbd);
    int k;
    k = 0;
    for (int i = 0; i < 16; i++) begin
      if (mask[i]) begin
        check(mem.wrAddr[k], a0 + 32'h4 * 32'(k));
        check(mem.wrData[k], (i == uk) ? UNK : rf[i]);
        k++;
      end
    end
    check(mem.wrCount, 32'(k));
    check({29'h0, wbHit, faultHit, undefHit}, {29'h0, flg});
    if (flg[2]) begin
      check({28'h0, wbRegHit}, {28'h0, wr_});
      check(wbDataHit, wbd);
    end
  endtask
  initial begin
    for (int i = 0; i < 16; i++) rf[i] = 32'h0a00_0000 + 32'h0101 * 32'(i);
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    rd_chk(`OFF_CTRL, 32'h1, 1'b0);
    rd_chk(`OFF_STAT, 32'h0, 1'b0);
    wr(`OFF_SPLIM, 32'h3000_0000);
    rd_chk(`OFF_SPLIM, 32'h3000_0000, 1'b0);
    rd_chk(12'h00c, 32'h0, 1'b1);
    stall = 4'h2;
    rf[2] = 32'h2000;
    run({16'h0, 5'h18, 3'h2, 8'h91}, 1'b0, 1'b1);
    judge(32'h2000, 16'h0091, 16, 3'b100, 4'h2, 32'h200c);
    run({16'h0, 5'h18, 3'h2, 8'h91}, 1'b0, 1'b0);
    judge(32'h0, 16'h0, 16, 3'b000, 4'h0, 32'h0);
    check(32'(doneCycles), 32'h1);
    stall = 4'h0;
    rf[1] = 32'h3000;
    run({16'h0, 5'h18, 3'h1, 8'h07}, 1'b0, 1'b1);
    judge(32'h3000, 16'h0007, 1, 3'b100, 4'h1, 32'h300c);
    wr(`OFF_CTRL, 32'h5);
    rf[13] = 32'h2fff_fff0;
    run(enc32(10'h3a2, 1'b1, 4'hd, 1'b0, 13'h7), 1'b1, 1'b1);
    judge(32'h0, 16'h0, 16, 3'b010, 4'h0, 32'h0);
    rd_chk(`OFF_STAT, 32'h2, 1'b0);
    wr(`OFF_STAT, 32'h2);
    rd_chk(`OFF_STAT, 32'h0, 1'b0);
    rf[13] = 32'h3000_0000;
    run(enc32(10'h3a2, 1'b1, 4'hd, 1'b0, 13'h7), 1'b1, 1'b1);
    judge(32'h3000_0000, 16'h7, 16, 3'b100, 4'hd, 32'h3000_000c);
    rf[13] = 32'h3000_0008;
    run(enc32(10'h3a4, 1'b1, 4'hd, 1'b0, 13'h7), 1'b1, 1'b1);
    judge(32'h0, 16'h0, 16, 3'b010, 4'h0, 32'h0);
    rf[13] = 32'h3000_000c;
    run(enc32(10'h3a4, 1'b1, 4'hd, 1'b0, 13'h7), 1'b1, 1'b1);
    judge(32'h3000_0000, 16'h7, 16, 3'b100, 4'hd, 32'h3000_0000);
    wr(`OFF_CTRL, 32'h1);
    rf[4] = 32'h4000;
    run(enc32(10'h3a4, 1'b1, 4'h4, 1'b1, 13'h21), 1'b1, 1'b1);
    judge(32'h3ff4, 16'h4021, 16, 3'b100, 4'h4, 32'h3ff4);
    run(enc32(10'h3a4, 1'b0, 4'h4, 1'b1, 13'h21), 1'b1, 1'b1);
    judge(32'h3ff4, 16'h4021, 16, 3'b000, 4'h0, 32'h0);
    rf[13] = 32'h5000;
    run({16'h0, 7'h5a, 1'b1, 8'h0a}, 1'b0, 1'b1);
    judge(32'h4ff4, 16'h400a, 16, 3'b100, 4'hd, 32'h4ff4);
    rf[3] = 32'h6000;
    run({16'h0, 5'h0c, 5'h1f, 3'h3, 3'h6}, 1'b0, 1'b1);
    judge(32'h607c, 16'h0040, 16, 3'b000, 4'h0, 32'h0);
    run({16'h0, 5'h12, 3'h5, 8'hff}, 1'b0, 1'b1);
    judge(32'h53fc, 16'h0020, 16, 3'b000, 4'h0, 32'h0);
    run({12'hf8c, 4'hf, 4'h7, 12'h004}, 1'b1, 1'b1);
    judge(32'h0, 16'h0, 16, 3'b001, 4'h0, 32'h0);
    run(enc32(10'h3a4, 1'b0, 4'hf, 1'b0, 13'h3), 1'b1, 1'b1);
    judge(32'h0, 16'h0, 16, 3'b001, 4'h0, 32'h0);
    run(enc32(10'h3a4, 1'b0, 4'h4, 1'b0, 13'h4), 1'b1, 1'b1);
    judge(32'h3ffc, 16'h0004, 16, 3'b000, 4'h0, 32'h0);
    run(enc32(10'h3a4, 1'b1, 4'h4, 1'b0, 13'h12), 1'b1, 1'b1);
    judge(32'h3ff8, 16'h0012, 4, 3'b100, 4'h4, 32'h3ff8);
    wr(`OFF_CTRL, 32'h0);
    run(enc32(10'h3a4, 1'b0, 4'h4, 1'b0, 13'h3), 1'b1, 1'b1);
    judge(32'h0, 16'h0, 16, 3'b001, 4'h0, 32'h0);
    wr(`OFF_CTRL, 32'h3);
    run({16'h0, 5'h18, 3'h2, 8'h00}, 1'b0, 1'b1);
    judge(32'h0, 16'h0, 16, 3'b000, 4'h0, 32'h0);
    run({12'hf8c, 4'h4, 4'h7, 12'h124}, 1'b1, 1'b1);
    judge(32'h4124, 16'h0080, 16, 3'b000, 4'h0, 32'h0);
    run({12'hf8c, 4'h4, 4'hf, 12'h124}, 1'b1, 1'b1);
    judge(32'h0, 16'h0, 16, 3'b000, 4'h0, 32'h0);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
